//--- fsq_top.sv
// code flash sequencer with wishbone registers and boot select
`timescale 1ns/1ps
module fsq_top #(
   parameter int OP_CYCLES = fsq_pkg::OP_CYCLES
) (
   // clock and reset
   input  wire logic                 ref_clk,
   input  wire logic                 reset,
   // wishbone slave
   input  wire logic                 cyc_i,
   input  wire logic                 stb_i,
   input  wire logic                 we_i,
   input  wire logic [7:0]           adr_i,
   input  wire logic [31:0]          dat_i,
   input  wire logic [3:0]           sel_i,
   output logic                      ack_o,
   output logic [31:0]               dat_o,
   // table read port
   input  wire logic                 tread_req,
   input  wire logic [12:0]          tread_addr,
   output fsq_pkg::tread_rsp_s       tread_rsp,
   // instruction fetch watch
   input  wire logic                 fetch_valid,
   input  wire logic [15:0]          fetch_addr,
   output logic                      rom_entry_hit,
   // boot selection
   input  wire logic                 force_loader,
   output logic [15:0]               start_addr,
   output logic                      start_valid,
   output logic [7:0]                option_live,
   // status
   output logic                      busy
);
   localparam int AW = fsq_pkg::ADDR_W;
   localparam int SW = fsq_pkg::SEC_W;
   localparam int PW = fsq_pkg::PAGE_W;

   typedef enum logic [1:0] {S_IDLE, S_SWEEP, S_WAIT} state_e;

   state_e              state_ff;
   state_e              nxt_state;
   logic [7:0]          mem [2**AW];
   logic [7:0]          pbuf [fsq_pkg::PAGE_B];
   logic [fsq_pkg::PAGE_B-1:0] pvalid_ff;
   logic [7:0]          sec_ff [fsq_pkg::SECTORS] =
                           '{default: fsq_pkg::SECURE_RST};
   logic [7:0]          data_ff;
   logic [7:0]          addr_lo_ff;
   logic [7:0]          addr_hi_ff;
   logic [7:0]          bvec_ff   = fsq_pkg::BVEC_RST;
   logic [7:0]          bstat_ff  = fsq_pkg::BSTAT_RST;
   logic [7:0]          option_ff = fsq_pkg::OPTION_RST;
   fsq_pkg::op_e        op_ff;
   logic [AW-1:0]       ptr_ff;
   logic [AW-1:0]       last_ff;
   logic                done_ff;
   logic                reject_ff;
   logic                loader_ff;
   logic                ack_ff;
   logic [31:0]         dat_o_ff;
   fsq_pkg::tread_rsp_s tread_ff;
   logic                rom_hit_ff;
   logic                boot_pend_ff;
   logic [15:0]         start_ff;
   logic                start_valid_ff;
   logic [7:0]          option_live_ff;
   logic                busy_ff;
   logic                expired;
   logic [31:0]         crc_val;

   // ---------------------------------------------
   // command classes
   // ---------------------------------------------
   function automatic logic is_erase(input fsq_pkg::op_e op);
      return op inside {fsq_pkg::OP_ERASE_BYTE, fsq_pkg::OP_ERASE_PAGE,
                        fsq_pkg::OP_ERASE_SECTOR, fsq_pkg::OP_ERASE_CHIP};
   endfunction : is_erase

   function automatic logic is_prog(input fsq_pkg::op_e op);
      return op inside {fsq_pkg::OP_PROG_BYTE, fsq_pkg::OP_PROG_PAGE};
   endfunction : is_prog

   function automatic logic is_crc(input fsq_pkg::op_e op);
      return op inside {fsq_pkg::OP_CRC_SECTOR, fsq_pkg::OP_CRC_ALL};
   endfunction : is_crc

   function automatic logic is_set(input fsq_pkg::op_e op);
      return op inside {fsq_pkg::OP_SET_SECURE, fsq_pkg::OP_SET_BVEC,
                        fsq_pkg::OP_SET_BSTAT, fsq_pkg::OP_SET_OPTION};
   endfunction : is_set

   // first or last address touched by an operation
   function automatic logic [AW-1:0] span(input fsq_pkg::op_e op,
                                          input logic [AW-1:0] a,
                                          input logic fill);
      if (op inside {fsq_pkg::OP_ERASE_CHIP, fsq_pkg::OP_CRC_ALL}) begin
         return {AW{fill}};
      end
      if (op inside {fsq_pkg::OP_ERASE_SECTOR, fsq_pkg::OP_CRC_SECTOR}) begin
         return {a[AW-1:SW], {SW{fill}}};
      end
      if (op inside {fsq_pkg::OP_ERASE_PAGE, fsq_pkg::OP_PROG_PAGE}) begin
         return {a[AW-1:PW], {PW{fill}}};
      end
      return a;
   endfunction : span

   // ---------------------------------------------
   // bus decode
   // ---------------------------------------------
   wire logic req     = cyc_i && stb_i && !ack_ff;
   wire logic wr      = req && we_i && sel_i[0];
   wire logic ctrl_wr = wr && (adr_i == fsq_pkg::OFF_CTRL);
   wire logic idle    = (state_ff == S_IDLE);
   wire logic accept  = ctrl_wr && idle;
   wire logic reject  = ctrl_wr && !idle;
   wire fsq_pkg::op_e new_op = fsq_pkg::op_e'(dat_i[3:0]);
   wire logic [AW-1:0] cur_addr = {addr_hi_ff[AW-9:0], addr_lo_ff};
   wire logic new_sweep = is_erase(new_op) || is_prog(new_op)
                          || is_crc(new_op);
   wire logic new_timed = is_erase(new_op) || is_prog(new_op)
                          || is_set(new_op);
   wire logic [PW-1:0] pidx = ptr_ff[PW-1:0];
   wire logic at_last  = (ptr_ff == last_ff);
   wire logic [2:0] cur_sec = cur_addr[AW-1:SW];

   // ---------------------------------------------
   // sequencing
   // ---------------------------------------------
   wire logic sweeping = (state_ff == S_SWEEP);
   wire logic wr_byte  = sweeping && (is_erase(op_ff) || is_prog(op_ff))
                         && (op_ff != fsq_pkg::OP_PROG_PAGE || pvalid_ff[pidx]);
   wire logic [7:0] wr_val = is_erase(op_ff) ? fsq_pkg::ERASED :
                     (op_ff == fsq_pkg::OP_PROG_PAGE) ? pbuf[pidx] : data_ff;
   wire logic wait_end = (state_ff == S_WAIT) && expired;
   wire logic finish   = wait_end || (sweeping && at_last && is_crc(op_ff))
                         || (accept && !new_sweep && !new_timed);

   // next state of the operation sequencer
   always_comb begin
      nxt_state = state_ff;
      unique case (state_ff)
         S_IDLE: begin
            if (accept && new_sweep) begin
               nxt_state = S_SWEEP;
            end else if (accept && new_timed) begin
               nxt_state = S_WAIT;
            end
         end
         S_SWEEP: begin
            if (at_last) begin
               nxt_state = is_crc(op_ff) ? S_IDLE : S_WAIT;
            end
         end
         S_WAIT: begin
            if (expired) begin
               nxt_state = S_IDLE;
            end
         end
      endcase
   end

   // state, operation latch and sweep pointer
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         state_ff <= S_IDLE;
         op_ff    <= fsq_pkg::OP_NOP;
         ptr_ff   <= '0;
         last_ff  <= '0;
      end else begin
         state_ff <= nxt_state;
         if (accept) begin
            op_ff   <= new_op;
            ptr_ff  <= span(new_op, cur_addr, 1'b0);
            last_ff <= span(new_op, cur_addr, 1'b1);
         end else if (sweeping && !at_last) begin
            ptr_ff <= ptr_ff + 1'b1;
         end
      end
   end

   // array writes, one byte per sweep cycle
   always_ff @(posedge ref_clk) begin
      if (wr_byte) begin
         mem[ptr_ff] <= wr_val;
      end
   end

   // page buffer loads and valid marks
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         pvalid_ff <= '0;
      end else if (accept && new_op == fsq_pkg::OP_LOAD) begin
         pvalid_ff[cur_addr[PW-1:0]] <= 1'b1;
      end else if ((accept && new_op == fsq_pkg::OP_CLR_BUF)
                   || (wait_end && op_ff == fsq_pkg::OP_PROG_PAGE)) begin
         pvalid_ff <= '0;
      end
   end
   always_ff @(posedge ref_clk) begin
      if (accept && new_op == fsq_pkg::OP_LOAD) begin
         pbuf[cur_addr[PW-1:0]] <= data_ff;
      end
   end

   // status flags; completion wins over the clearing accept
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         done_ff   <= 1'b0;
         reject_ff <= 1'b0;
         loader_ff <= 1'b1;
         busy_ff   <= 1'b0;
      end else begin
         busy_ff <= (nxt_state != S_IDLE);
         if (finish) begin
            done_ff <= 1'b1;
         end else if (accept) begin
            done_ff <= 1'b0;
         end
         if (reject) begin
            reject_ff <= 1'b1;
         end else if (accept) begin
            reject_ff <= 1'b0;
         end
         if (wr_byte && ptr_ff >= fsq_pkg::LOADER_BASE) begin
            loader_ff <= 1'b0;
         end
      end
   end

   // nonvolatile elements: factory values at power-up, kept through
   // reset so that boot status and option act at the next boot
   always_ff @(posedge ref_clk) begin
      if (wait_end && !reset) begin
         unique case (op_ff)
            fsq_pkg::OP_SET_SECURE: sec_ff[ptr_ff[AW-1:SW]] <= data_ff;
            fsq_pkg::OP_SET_BVEC:   bvec_ff   <= data_ff;
            fsq_pkg::OP_SET_BSTAT:  bstat_ff  <= data_ff;
            fsq_pkg::OP_SET_OPTION: option_ff <= data_ff;
            default: ;
         endcase
      end
   end

   // ---------------------------------------------
   // helpers
   // ---------------------------------------------
   fsq_op_timer #(
      .LIMIT (OP_CYCLES)
   ) u_timer (
      .ref_clk (ref_clk),
      .reset   (reset),
      .start   (accept && new_timed),
      .expired (expired)
   );

   fsq_crc32 u_crc (
      .ref_clk (ref_clk),
      .reset   (reset),
      .clear   (accept && is_crc(new_op)),
      .en      (sweeping && is_crc(op_ff)),
      .byte_in (mem[ptr_ff]),
      .crc     (crc_val)
   );

   // ---------------------------------------------
   // wishbone registers
   // ---------------------------------------------
   wire logic [31:0] status = {28'h0000000, loader_ff, reject_ff,
                               done_ff, busy_ff};
   wire logic [31:0] rd_mux =
      (adr_i == fsq_pkg::OFF_CTRL)    ? status :
      (adr_i == fsq_pkg::OFF_DATA)    ? {24'h000000, data_ff} :
      (adr_i == fsq_pkg::OFF_ADDR_LO) ? {24'h000000, addr_lo_ff} :
      (adr_i == fsq_pkg::OFF_ADDR_HI) ? {24'h000000, addr_hi_ff} :
      (adr_i == fsq_pkg::OFF_CRC)     ? crc_val :
      (adr_i == fsq_pkg::OFF_BOOT)    ? {8'h00, option_ff, bvec_ff, bstat_ff} :
      (adr_i == fsq_pkg::OFF_SECURE)  ? {24'h000000, sec_ff[cur_sec]} :
                                        32'h00000000;

   // one-wait-state ack, data and address latches
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         ack_ff     <= 1'b0;
         dat_o_ff   <= '0;
         data_ff    <= '0;
         addr_lo_ff <= '0;
         addr_hi_ff <= '0;
      end else begin
         ack_ff <= req;
         if (req && !we_i) begin
            dat_o_ff <= rd_mux;
         end
         if (wr && adr_i == fsq_pkg::OFF_DATA) begin
            data_ff <= dat_i[7:0];
         end
         if (wr && adr_i == fsq_pkg::OFF_ADDR_LO) begin
            addr_lo_ff <= dat_i[7:0];
         end
         if (wr && adr_i == fsq_pkg::OFF_ADDR_HI) begin
            addr_hi_ff <= dat_i[7:0];
         end
      end
   end

   // ---------------------------------------------
   // table read, rom entry, boot selection
   // ---------------------------------------------
   wire logic t_secure = (sec_ff[tread_addr[AW-1:SW]] != 8'h00);
   wire logic boot_alt = force_loader || (bstat_ff != 8'h00);

   always_ff @(posedge ref_clk) begin
      if (reset) begin
         tread_ff   <= '0;
         rom_hit_ff <= 1'b0;
      end else begin
         tread_ff.ok      <= tread_req && !t_secure;
         tread_ff.refused <= tread_req && t_secure;
         tread_ff.data    <= (tread_req && !t_secure) ?
                             mem[tread_addr] : 8'h00;
         rom_hit_ff <= fetch_valid
                       && (fetch_addr == fsq_pkg::ROM_ENTRY);
      end
   end

   // strap and option caught on the first edge after reset release
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         boot_pend_ff   <= 1'b1;
         start_ff       <= '0;
         start_valid_ff <= 1'b0;
         option_live_ff <= '0;
      end else if (boot_pend_ff) begin
         boot_pend_ff   <= 1'b0;
         start_valid_ff <= 1'b1;
         option_live_ff <= option_ff;
         start_ff <= boot_alt ? {bvec_ff, fsq_pkg::START_LOW}
                              : fsq_pkg::USER_START;
      end
   end

   assign ack_o         = ack_ff;
   assign dat_o         = dat_o_ff;
   assign tread_rsp     = tread_ff;
   assign rom_entry_hit = rom_hit_ff;
   assign start_addr    = start_ff;
   assign start_valid   = start_valid_ff;
   assign option_live   = option_live_ff;
   assign busy          = busy_ff;

   // ---------------------------------------------
   // assertions
   // ---------------------------------------------
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (reset);

   property p_ack_pulse;
      req ##1 ack_ff |=> !ack_ff;
   endproperty
   a_ack_pulse: assert property (p_ack_pulse)
      else $error("ack held longer than one cycle");

   property p_reject;
      reject |=> reject_ff && $stable(op_ff);
   endproperty
   a_reject: assert property (p_reject)
      else $error("command taken while busy");

   property p_busy;
      accept && new_timed |=> busy_ff [*2];
   endproperty
   a_busy: assert property (p_busy)
      else $error("busy not shown during operation");

   property p_refuse;
      tread_req && t_secure |=> tread_ff.refused && tread_ff.data == 8'h00;
   endproperty
   a_refuse: assert property (p_refuse)
      else $error("secured byte returned");

   property p_boot_user;
      boot_pend_ff && !boot_alt |=> start_ff == 16'h0000 && start_valid_ff;
   endproperty
   a_boot_user: assert property (p_boot_user)
      else $error("user start address wrong");

   property p_boot_vec;
      boot_pend_ff && boot_alt |=> start_ff == {$past(bvec_ff), 8'h00};
   endproperty
   a_boot_vec: assert property (p_boot_vec)
      else $error("vectored start address wrong");

   property p_option_fixed;
      !boot_pend_ff |=> $stable(option_live_ff);
   endproperty
   a_option_fixed: assert property (p_option_fixed)
      else $error("option changed after power-up");

   property p_rom_entry;
      fetch_valid && fetch_addr == 16'hff03 |=> rom_hit_ff;
   endproperty
   a_rom_entry: assert property (p_rom_entry)
      else $error("rom entry not flagged");

   property p_page_mask;
      sweeping && op_ff == fsq_pkg::OP_PROG_PAGE && !pvalid_ff[pidx]
         |-> !wr_byte;
   endproperty
   a_page_mask: assert property (p_page_mask)
      else $error("unloaded byte programmed");

   property p_sweep_end;
      sweeping && at_last && !is_crc(op_ff) |=> state_ff == S_WAIT;
   endproperty
   a_sweep_end: assert property (p_sweep_end)
      else $error("sweep did not end in wait");
endmodule : fsq_top

//--- fsq_pkg.sv
// types and constants of the code flash sequencer
// Operation
// - erase a single sector or page
// - chip erase clears the whole array
// - eight 1 kB sectors of 64-byte pages
// - page buffer programs 1 to 64 bytes
// - each byte erasable and programmable alone
// - table read refused in secured sectors
// - every program or erase ends within 2 ms
// - CRC-32 over one sector or all code
// - no raw array readback over registers
// - boot status zero starts at 0000H
// - nonzero status starts at vector, low 00H
// - factory vector 1FH gives loader 1F00H
// - loader strap acts like nonzero status
// - control, data and two address registers
// - boot ROM services entered at FF03H
// - option byte sampled once after each reset release
// - one security byte per sector
// - factory loader occupies 1E00H to 1FFFH
package fsq_pkg;
   // ---------------------------------------------
   // array geometry
   // ---------------------------------------------
   localparam int ADDR_W  = 13;
   localparam int SECTORS = 8;
   localparam int SEC_W   = 10;
   localparam int PAGE_W  = 6;
   localparam int PAGE_B  = 64;
   localparam logic [7:0] ERASED = 8'hff;
   // ---------------------------------------------
   // register offsets and status fields
   // ---------------------------------------------
   localparam logic [7:0] OFF_CTRL    = 8'h00;
   localparam logic [7:0] OFF_DATA    = 8'h04;
   localparam logic [7:0] OFF_ADDR_LO = 8'h08;
   localparam logic [7:0] OFF_ADDR_HI = 8'h0c;
   localparam logic [7:0] OFF_CRC     = 8'h10;
   localparam logic [7:0] OFF_BOOT    = 8'h14;
   localparam logic [7:0] OFF_SECURE  = 8'h18;
   localparam int ST_BUSY   = 0;
   localparam int ST_DONE   = 1;
   localparam int ST_REJECT = 2;
   localparam int ST_LOADER = 3;
   // ---------------------------------------------
   // boot and factory values
   // ---------------------------------------------
   localparam logic [15:0] USER_START  = 16'h0000;
   localparam logic [7:0]  START_LOW   = 8'h00;
   localparam logic [7:0]  BVEC_RST    = 8'h1f;
   localparam logic [7:0]  BSTAT_RST   = 8'h01;
   localparam logic [7:0]  OPTION_RST  = 8'h00;
   localparam logic [7:0]  SECURE_RST  = 8'h00;
   localparam logic [15:0] ROM_ENTRY   = 16'hff03;
   localparam logic [12:0] LOADER_BASE = 13'h1e00;
   // ---------------------------------------------
   // crc and timing
   // ---------------------------------------------
   localparam logic [31:0] CRC_POLY = 32'hedb88320;
   localparam logic [31:0] CRC_INIT = 32'hffffffff;
   localparam int OP_TIME_US = 2000;
   localparam int CLK_KHZ    = 20000;
   localparam int OP_CYCLES  = OP_TIME_US * CLK_KHZ / 1000;
   // ---------------------------------------------
   // commands and carriers
   // ---------------------------------------------
   typedef enum logic [3:0] {
      OP_NOP, OP_LOAD, OP_PROG_BYTE, OP_ERASE_BYTE, OP_PROG_PAGE,
      OP_ERASE_PAGE, OP_ERASE_SECTOR, OP_ERASE_CHIP, OP_CRC_SECTOR,
      OP_CRC_ALL, OP_CLR_BUF, OP_SET_SECURE, OP_SET_BVEC,
      OP_SET_BSTAT, OP_SET_OPTION
   } op_e;
   typedef struct packed {
      logic       ok;
      logic       refused;
      logic [7:0] data;
   } tread_rsp_s;
endpackage : fsq_pkg

//--- fsq_op_timer.sv
// timing generator for one program or erase operation
`timescale 1ns/1ps
module fsq_op_timer #(
   parameter int LIMIT = fsq_pkg::OP_CYCLES,
   parameter int CNT_W = 16
) (
   // clock and reset
   input  wire logic ref_clk,
   input  wire logic reset,
   // control
   input  wire logic start,
   output logic      expired
);
   logic [CNT_W-1:0] cnt_ff;
   logic             run_ff;
   logic             exp_ff;
   wire logic        last = (cnt_ff == CNT_W'(LIMIT - 1));

   // count LIMIT cycles from start, then hold expired
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         cnt_ff <= '0;
         run_ff <= 1'b0;
         exp_ff <= 1'b0;
      end else if (start) begin
         cnt_ff <= '0;
         run_ff <= 1'b1;
         exp_ff <= 1'b0;
      end else if (run_ff) begin
         cnt_ff <= cnt_ff + 1'b1;
         run_ff <= !last;
         exp_ff <= last;
      end
   end
   assign expired = exp_ff;

   property p_expire_at_limit;
      @(posedge ref_clk) disable iff (reset)
      $rose(exp_ff) |-> $past(cnt_ff) == CNT_W'(LIMIT - 1);
   endproperty
   a_expire_at_limit: assert property (p_expire_at_limit)
      else $error("timer expired at wrong count");
endmodule : fsq_op_timer

//--- fsq_crc32.sv
// byte-serial crc-32 over swept array contents
`timescale 1ns/1ps
module fsq_crc32 (
   // clock and reset
   input  wire logic        ref_clk,
   input  wire logic        reset,
   // byte stream
   input  wire logic        clear,
   input  wire logic        en,
   input  wire logic [7:0]  byte_in,
   output logic      [31:0] crc
);
   logic [31:0] crc_ff;

   // reflected crc-32 update by one byte
   function automatic logic [31:0] crc_step(input logic [31:0] c,
                                            input logic [7:0]  b);
      logic [31:0] r;
      r = c ^ {24'h000000, b};
      for (int i = 0; i < 8; i++) begin
         r = r[0] ? ((r >> 1) ^ fsq_pkg::CRC_POLY) : (r >> 1);
      end
      return r;
   endfunction : crc_step

   // accumulate while enabled, restart on clear
   always_ff @(posedge ref_clk) begin
      if (reset || clear) begin
         crc_ff <= fsq_pkg::CRC_INIT;
      end else if (en) begin
         crc_ff <= crc_step(crc_ff, byte_in);
      end
   end
   assign crc = ~crc_ff;

   property p_crc_restart;
      @(posedge ref_clk) disable iff (reset)
      clear |=> crc_ff == fsq_pkg::CRC_INIT;
   endproperty
   a_crc_restart: assert property (p_crc_restart)
      else $error("crc did not restart");
endmodule : fsq_crc32

//--- wb_host.sv
// wishbone master standing for the firmware side of the registers
`timescale 1ns/1ps
module wb_host (
   // clock
   input  wire logic        ref_clk,
   // wishbone master
   output logic             cyc_o,
   output logic             stb_o,
   output logic             we_o,
   output logic [7:0]       adr_o,
   output logic [31:0]      dat_o,
   output logic [3:0]       sel_o,
   input  wire logic        ack_i,
   input  wire logic [31:0] dat_i
);
   // idle bus at time zero
   initial begin
      {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} = '0;
   end
   // one classic cycle, held until ack is sampled
   task automatic xfer(input logic w, input logic [7:0] a,
      input logic [31:0] d, output logic [31:0] q, output logic ok);
      int n;
      ok = 1'b0;
      q = '0;
      @(posedge ref_clk);
      {cyc_o, stb_o, we_o, adr_o, dat_o, sel_o} <= {2'b11, w, a, d, 4'hf};
      for (n = 0; n < 40 && !ok; n++) begin
         @(posedge ref_clk);
         ok = (ack_i === 1'b1);
         q = dat_i;
      end
      {cyc_o, stb_o} <= 2'b00;
      dat_o <= ~d; // released bus shows no stale data
   endtask : xfer
endmodule : wb_host

//--- tb_top.sv
// self-checking bench of the code flash sequencer
`timescale 1ns/1ps
module tb_top;
   logic ref_clk = 1'b0, reset = 1'b1;
   logic cyc, stb, we, ack, tread_req = 1'b0, fetch_valid = 1'b0;
   logic [7:0] adr, option_live;
   logic [31:0] wdat, rdat, rdat_q;
   logic [3:0] sel;
   logic [12:0] tread_addr = '0;
   logic [15:0] fetch_addr = '0, start_addr;
   logic start_valid, rom_entry_hit, busy, force_loader = 1'b0;
   fsq_pkg::tread_rsp_s tread_rsp;
   int n_mismatch = 0, checks_done = 0;
   wb_host host_u (.ref_clk(ref_clk), .cyc_o(cyc), .stb_o(stb), .we_o(we),
      .adr_o(adr), .dat_o(wdat), .sel_o(sel), .ack_i(ack), .dat_i(rdat));
   fsq_top #(.OP_CYCLES(16)) dut_u (.ref_clk(ref_clk), .reset(reset),
      .cyc_i(cyc), .stb_i(stb), .we_i(we), .adr_i(adr), .dat_i(wdat),
      .sel_i(sel), .ack_o(ack), .dat_o(rdat), .tread_req(tread_req),
      .tread_addr(tread_addr), .tread_rsp(tread_rsp),
      .fetch_valid(fetch_valid), .fetch_addr(fetch_addr),
      .rom_entry_hit(rom_entry_hit), .force_loader(force_loader),
      .start_addr(start_addr), .start_valid(start_valid),
      .option_live(option_live), .busy(busy));
   // clock of 50 ns
   initial begin
      forever #25 ref_clk = ~ref_clk;
   end
   task automatic close_out();
      $display("checks %0d mismatches %0d", checks_done, n_mismatch);
      if (n_mismatch == 0 && checks_done > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : close_out
   task automatic chk(string nm, logic [31:0] e, logic [31:0] g);
      checks_done++;
      if (g !== e) begin
         n_mismatch++;
         $display("BAD %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   task automatic rw(logic w, logic [7:0] a, logic [31:0] d);
      logic ok;
      host_u.xfer(w, a, d, rdat_q, ok);
      if (!ok) begin
         n_mismatch++;
         close_out();
      end
   endtask : rw
   // expected crc of n erased bytes
   function automatic logic [31:0] crc_ones(int n);
      logic [31:0] c;
      c = fsq_pkg::CRC_INIT;
      for (int k = 0; k < n * 8; k++) begin
         if (k % 8 == 0) c = c ^ 32'hff;
         c = c[0] ? ((c >> 1) ^ fsq_pkg::CRC_POLY) : (c >> 1);
      end
      return ~c;
   endfunction : crc_ones
   task automatic boot_again();
      @(posedge ref_clk);
      reset <= 1'b1;
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
   endtask : boot_again
   // load address and data, issue a command, wait for completion
   task automatic cmd(fsq_pkg::op_e op, logic [12:0] a, logic [7:0] d);
      int n;
      rw(1'b1, fsq_pkg::OFF_ADDR_LO, {24'h0, a[7:0]});
      rw(1'b1, fsq_pkg::OFF_ADDR_HI, {27'h0, a[12:8]});
      rw(1'b1, fsq_pkg::OFF_DATA, {24'h0, d});
      rw(1'b1, fsq_pkg::OFF_CTRL, {28'h0, op});
      for (n = 0; n < 3000; n++) begin
         rw(1'b0, fsq_pkg::OFF_CTRL, 32'h0);
         if (rdat_q[1:0] === 2'b10) break;
      end
      if (n == 3000) begin
         n_mismatch++;
         close_out();
      end
   endtask : cmd
   task automatic tread(logic [12:0] a, logic [9:0] e);
      @(posedge ref_clk);
      tread_req <= 1'b1;
      tread_addr <= a;
      @(posedge ref_clk);
      tread_req <= 1'b0;
      @(posedge ref_clk);
      chk("tread_rsp", {22'h0, e}, {22'h0, tread_rsp});
   endtask : tread
   task automatic t_boot();
      chk("start_addr", 32'h1f00, {16'h0, start_addr});
      chk("start_valid", 32'h1, {31'h0, start_valid});
      chk("option_live", 32'h0, {24'h0, option_live});
      rw(1'b0, fsq_pkg::OFF_BOOT, 32'h0);
      chk("boot reg", 32'h001f01, rdat_q);
      rw(1'b0, 8'h40, 32'h0);
      chk("unmapped", 32'h0, rdat_q);
      $display("boot test done");
   endtask : t_boot
   task automatic t_byte();
      cmd(fsq_pkg::OP_PROG_BYTE, 13'h0005, 8'h5a);
      tread(13'h0005, 10'h25a);
      cmd(fsq_pkg::OP_ERASE_BYTE, 13'h0005, 8'h00);
      tread(13'h0005, 10'h2ff);
      $display("byte test done");
   endtask : t_byte
   task automatic t_reject();
      rw(1'b1, fsq_pkg::OFF_CTRL, {28'h0, fsq_pkg::OP_ERASE_PAGE});
      chk("busy", 32'h1, {31'h0, busy});
      rw(1'b1, fsq_pkg::OFF_CTRL, {28'h0, fsq_pkg::OP_PROG_BYTE});
      rw(1'b0, fsq_pkg::OFF_CTRL, 32'h0);
      chk("status reject", 32'hd, {28'h0, rdat_q[3:0]});
      cmd(fsq_pkg::OP_NOP, 13'h0, 8'h00);
      tread(13'h0005, 10'h2ff);
      $display("reject test done");
   endtask : t_reject
   task automatic t_secure();
      cmd(fsq_pkg::OP_PROG_BYTE, 13'h0410, 8'h33);
      cmd(fsq_pkg::OP_SET_SECURE, 13'h0400, 8'h01);
      tread(13'h0410, 10'h100);
      cmd(fsq_pkg::OP_PROG_BYTE, 13'h0011, 8'h77);
      tread(13'h0011, 10'h277);
      $display("secure test done");
   endtask : t_secure
   task automatic t_fetch();
      @(posedge ref_clk);
      fetch_valid <= 1'b1;
      fetch_addr <= fsq_pkg::ROM_ENTRY;
      @(posedge ref_clk);
      fetch_valid <= 1'b0;
      @(posedge ref_clk);
      chk("rom_entry_hit", 32'h1, {31'h0, rom_entry_hit});
      $display("fetch test done");
   endtask : t_fetch
   task automatic t_array();
      cmd(fsq_pkg::OP_PROG_BYTE, 13'h0855, 8'h12);
      cmd(fsq_pkg::OP_ERASE_SECTOR, 13'h0800, 8'h00);
      tread(13'h0855, 10'h2ff);
      cmd(fsq_pkg::OP_ERASE_CHIP, 13'h0000, 8'h00);
      chk("status loader", 32'h2, {28'h0, rdat_q[3:0]});
      tread(13'h0011, 10'h2ff);
      cmd(fsq_pkg::OP_CRC_SECTOR, 13'h0800, 8'h00);
      rw(1'b0, fsq_pkg::OFF_CRC, 32'h0);
      chk("crc sector", crc_ones(1024), rdat_q);
      cmd(fsq_pkg::OP_CRC_ALL, 13'h0000, 8'h00);
      rw(1'b0, fsq_pkg::OFF_CRC, 32'h0);
      chk("crc all", crc_ones(8192), rdat_q);
      cmd(fsq_pkg::OP_LOAD, 13'h0c03, 8'hc3);
      cmd(fsq_pkg::OP_PROG_PAGE, 13'h0c00, 8'h00);
      tread(13'h0c03, 10'h2c3);
      tread(13'h0c04, 10'h2ff);
      $display("array test done");
   endtask : t_array
   task automatic t_warm();
      cmd(fsq_pkg::OP_SET_OPTION, 13'h0000, 8'h5a);
      cmd(fsq_pkg::OP_SET_BSTAT, 13'h0000, 8'h00);
      chk("option_live", 32'h0, {24'h0, option_live});
      boot_again();
      chk("start_addr", 32'h0, {16'h0, start_addr});
      chk("option_live", 32'h5a, {24'h0, option_live});
      cmd(fsq_pkg::OP_SET_BVEC, 13'h0000, 8'h0c);
      force_loader <= 1'b1;
      boot_again();
      chk("start_addr", 32'h0c00, {16'h0, start_addr});
      $display("warm boot test done");
   endtask : t_warm
   // main sequence
   initial begin
      repeat (3) @(posedge ref_clk);
      reset <= 1'b0;
      repeat (2) @(posedge ref_clk);
      t_boot();
      t_byte();
      t_reject();
      t_secure();
      t_fetch();
      t_array();
      t_warm();
      close_out();
   end
endmodule : tb_top
